//--- hw/plec_sat_counter.sv
`timescale 1ns/1ps
`default_nettype none

`include "plec_cfg.svh"

module plec_sat_counter (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic step_in,
  input wire logic hold_in,
  // Count
  output plec_pkg::plec_word_t count_out
);

  plec_pkg::plec_word_t count_reg;

  // Clear beats a step arriving in the same cycle, so a cleared count never starts at one.
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      count_reg <= 16'h0000;
    end else if (step_in && !hold_in && count_reg != `PLEC_COUNT_MAX) begin // [R13]
      count_reg <= count_reg + 16'h0001;
    end
  end

  assign count_out = count_reg;

endmodule : plec_sat_counter

`default_nettype wire

//--- hw/plec_top.sv
// Operation
// [R1] Length pulses from a digital input terminal are counted before any length setting matters.
// [R2] The measured length is the pulse total divided by pulses per metre and is unmet while below the set length.
// [R3] When the measured length reaches or passes the set length the length-reached output goes high.
// [R4] The length clear input zeroes the length count and drops the length-reached output.
// [R5] The pulse source must use the fast input terminal for rates above about 250 Hz.
// [R6] The present length count can be read back at any time.
// [R7] The event counter counts pulses from a digital input terminal and signals when a configured value is reached.
// [R8] The intermediate-reached output is high while the event count is not below the intermediate target.
// [R9] Counting goes on past the intermediate target and stops at the final target, which raises the final output.
// [R10] The counter clear input zeroes the event count and drops both reached outputs.
// [R11] The present event count can be read back in real time.
// [R12] With both event targets zero the event counter is off, and only one terminal feeds each counter.
// [R13] Each counter saturates at the top of its 16-bit range instead of wrapping.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "plec_cfg.svh"

module plec_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Pulse and clear inputs
  input wire logic length_pulse_in,
  input wire logic event_pulse_in,
  input wire logic fast_pulse_input_in,
  input wire logic length_clear_in,
  input wire logic event_clear_in,
  // Reach outputs and interrupt
  output logic length_reached_out,
  output logic intermediate_reached_out,
  output logic final_reached_out,
  output logic irq_out
);

  plec_pkg::plec_word_t target_length_reg;
  plec_pkg::plec_word_t pulses_per_metre_reg;
  plec_pkg::plec_word_t final_count_target_reg;
  plec_pkg::plec_word_t intermediate_count_target_reg;
  plec_pkg::plec_word_t length_resolution_select_reg;
  plec_pkg::plec_word_t fast_input_function_select_reg;
  plec_pkg::plec_flags_t irq_mask_reg;
  plec_pkg::plec_flags_t irq_status_reg;
  plec_pkg::plec_flags_t irq_status_next;
  plec_pkg::plec_bus_e bus_state_reg;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;

  logic length_src;
  logic event_src;
  logic length_src_reg;
  logic event_src_reg;
  logic length_step;
  logic event_step;
  plec_pkg::plec_word_t length_count_monitor;
  plec_pkg::plec_word_t event_count_monitor;
  plec_pkg::plec_word_t length_scale;
  logic [31:0] length_scaled;
  logic [31:0] length_target_scaled;
  logic length_met;
  logic event_enabled;
  logic event_hold;
  logic length_reached_reg;
  logic intermediate_reached_reg;
  logic final_reached_reg;
  logic length_reached_next;
  logic intermediate_reached_next;
  logic final_reached_next;
  logic bus_req;
  logic bus_done;
  logic wr_done;
  logic rd_done;

  function automatic plec_pkg::plec_word_t plec_merge(
    input plec_pkg::plec_word_t old_value,
    input logic [31:0] data,
    input logic [3:0] lanes
  );
    plec_pkg::plec_word_t merged;
    merged = old_value;
    if (lanes[0]) begin
      merged[7:0] = data[7:0];
    end
    if (lanes[1]) begin
      merged[15:8] = data[15:8];
    end
    return merged;
  endfunction : plec_merge

  // Bus handshake: every access is answered in its second cycle, so read data is settled a full cycle early.
  assign bus_req = avs_read_in || avs_write_in;
  assign bus_done = bus_req && (bus_state_reg == plec_pkg::PLEC_BUS_ANSWER);
  assign wr_done = avs_write_in && bus_done;
  assign rd_done = avs_read_in && bus_done;
  assign avs_waitrequest_out = bus_req && (bus_state_reg != plec_pkg::PLEC_BUS_ANSWER);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_state_reg <= plec_pkg::PLEC_BUS_IDLE;
    end else begin
      case (bus_state_reg)
        plec_pkg::PLEC_BUS_IDLE: begin
          if (bus_req) begin
            bus_state_reg <= plec_pkg::PLEC_BUS_ANSWER;
          end
        end
        plec_pkg::PLEC_BUS_ANSWER: begin
          bus_state_reg <= plec_pkg::PLEC_BUS_IDLE;
        end
        default: begin
          bus_state_reg <= plec_pkg::PLEC_BUS_IDLE;
        end
      endcase
    end
  end

  // Software settings.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      target_length_reg <= `PLEC_RST_TARGET_LENGTH;
      pulses_per_metre_reg <= `PLEC_RST_PULSES_PER_METRE;
      final_count_target_reg <= `PLEC_RST_FINAL_TARGET;
      intermediate_count_target_reg <= `PLEC_RST_INTER_TARGET;
      length_resolution_select_reg <= `PLEC_RST_RESOLUTION;
      fast_input_function_select_reg <= `PLEC_RST_FAST_SELECT;
      irq_mask_reg <= `PLEC_RST_IRQ_MASK;
    end else if (wr_done) begin
      case (avs_address_in)
        `PLEC_OFF_TARGET_LENGTH: begin
          target_length_reg <= plec_merge(target_length_reg, avs_writedata_in, avs_byteenable_in);
        end
        `PLEC_OFF_PULSES_PER_METRE: begin
          pulses_per_metre_reg <= plec_merge(pulses_per_metre_reg, avs_writedata_in, avs_byteenable_in);
        end
        `PLEC_OFF_FINAL_TARGET: begin
          final_count_target_reg <= plec_merge(final_count_target_reg, avs_writedata_in, avs_byteenable_in);
        end
        `PLEC_OFF_INTER_TARGET: begin
          intermediate_count_target_reg <= plec_merge(intermediate_count_target_reg, avs_writedata_in,
            avs_byteenable_in);
        end
        `PLEC_OFF_RESOLUTION: begin
          length_resolution_select_reg <= plec_merge(length_resolution_select_reg, avs_writedata_in,
            avs_byteenable_in);
        end
        `PLEC_OFF_FAST_SELECT: begin
          fast_input_function_select_reg <= plec_merge(fast_input_function_select_reg, avs_writedata_in,
            avs_byteenable_in);
        end
        `PLEC_OFF_IRQ_MASK: begin
          if (avs_byteenable_in[0]) begin
            irq_mask_reg <= avs_writedata_in[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data is captured on the first cycle of a read and stands through the answer cycle.
  always_comb begin
    readdata_next = 32'h00000000;
    case (avs_address_in)
      `PLEC_OFF_TARGET_LENGTH: readdata_next[15:0] = target_length_reg;
      `PLEC_OFF_PULSES_PER_METRE: readdata_next[15:0] = pulses_per_metre_reg;
      `PLEC_OFF_FINAL_TARGET: readdata_next[15:0] = final_count_target_reg;
      `PLEC_OFF_INTER_TARGET: readdata_next[15:0] = intermediate_count_target_reg;
      `PLEC_OFF_RESOLUTION: readdata_next[15:0] = length_resolution_select_reg;
      `PLEC_OFF_FAST_SELECT: readdata_next[15:0] = fast_input_function_select_reg;
      `PLEC_OFF_LENGTH_MONITOR: readdata_next[15:0] = length_count_monitor; // [R6]
      `PLEC_OFF_EVENT_MONITOR: readdata_next[15:0] = event_count_monitor; // [R11]
      `PLEC_OFF_IRQ_STATUS: readdata_next[2:0] = irq_status_reg;
      `PLEC_OFF_IRQ_MASK: readdata_next[2:0] = irq_mask_reg;
      `PLEC_OFF_FLAGS: readdata_next[2:0] = {final_reached_reg, intermediate_reached_reg, length_reached_reg};
      default: readdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      readdata_reg <= 32'h00000000;
    end else if (avs_read_in && !bus_done) begin
      readdata_reg <= readdata_next;
    end
  end

  assign avs_readdata_out = readdata_reg;

  // One pin feeds each counter; the fast terminal replaces the ordinary one when selected.
  assign length_src = (fast_input_function_select_reg == `PLEC_FSEL_LENGTH) ? fast_pulse_input_in
    : length_pulse_in; // [R12]
  assign event_src = (fast_input_function_select_reg == `PLEC_FSEL_EVENT) ? fast_pulse_input_in
    : event_pulse_in; // [R12]

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      length_src_reg <= 1'b0;
      event_src_reg <= 1'b0;
    end else begin
      length_src_reg <= length_src;
      event_src_reg <= event_src;
    end
  end

  assign length_step = length_src && !length_src_reg; // [R1]
  assign event_step = event_src && !event_src_reg; // [R7]

  plec_sat_counter u_length_counter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(length_clear_in), // [R4]
    .step_in(length_step), // [R1]
    .hold_in(1'b0),
    .count_out(length_count_monitor)
  );

  // Length is compared without a divider: N / (ppm / 10) >= L / 10^res, cross-multiplied.
  always_comb begin
    case (length_resolution_select_reg[1:0])
      2'h0: length_scale = `PLEC_SCALE_RES0;
      2'h1: length_scale = `PLEC_SCALE_RES1;
      2'h2: length_scale = `PLEC_SCALE_RES2;
      2'h3: length_scale = `PLEC_SCALE_RES3;
      default: length_scale = `PLEC_SCALE_RES0;
    endcase
  end

  assign length_scaled = {16'h0000, length_count_monitor} * {16'h0000, length_scale}; // [R2]
  assign length_target_scaled = {16'h0000, target_length_reg} * {16'h0000, pulses_per_metre_reg}; // [R2]
  // A zero factor would make every length infinite, so it never counts as met.
  assign length_met = (pulses_per_metre_reg != 16'h0000) && (length_scaled >= length_target_scaled); // [R3]

  assign length_reached_next = !length_clear_in && length_met; // [R4]

  assign event_enabled = (final_count_target_reg != 16'h0000) || (intermediate_count_target_reg != 16'h0000); // [R12]
  assign event_hold = !event_enabled || (event_count_monitor >= final_count_target_reg); // [R9]

  plec_sat_counter u_event_counter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(event_clear_in), // [R10]
    .step_in(event_step), // [R7]
    .hold_in(event_hold), // [R9]
    .count_out(event_count_monitor)
  );

  assign intermediate_reached_next = !event_clear_in && event_enabled
    && (event_count_monitor >= intermediate_count_target_reg); // [R8]
  assign final_reached_next = !event_clear_in && event_enabled
    && (event_count_monitor >= final_count_target_reg); // [R9]

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      length_reached_reg <= 1'b0;
      intermediate_reached_reg <= 1'b0;
      final_reached_reg <= 1'b0;
    end else begin
      length_reached_reg <= length_reached_next; // [R3]
      intermediate_reached_reg <= intermediate_reached_next; // [R8]
      final_reached_reg <= final_reached_next; // [R9]
    end
  end

  assign length_reached_out = length_reached_reg;
  assign intermediate_reached_out = intermediate_reached_reg;
  assign final_reached_out = final_reached_reg;

  // Only bits captured by the read are cleared, so a rise in the answer cycle survives.
  always_comb begin
    irq_status_next = irq_status_reg;
    if (rd_done && avs_address_in == `PLEC_OFF_IRQ_STATUS) begin
      irq_status_next = irq_status_reg & ~readdata_reg[2:0];
    end
    if (length_reached_next && !length_reached_reg) begin
      irq_status_next[`PLEC_BIT_LENGTH] = 1'b1;
    end
    if (intermediate_reached_next && !intermediate_reached_reg) begin
      irq_status_next[`PLEC_BIT_INTER] = 1'b1;
    end
    if (final_reached_next && !final_reached_reg) begin
      irq_status_next[`PLEC_BIT_FINAL] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status_reg <= 3'h0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  assign irq_out = |(irq_status_reg & irq_mask_reg);

  default clocking plec_cb @(posedge clk_in);
  endclocking

  default disable iff (rst_in);

  a_len_clear_drops: assert property (length_clear_in // [R4]
    |=> !length_reached_out && length_count_monitor == 16'h0000)
    else $error("length clear did not drop count and output");

  a_len_reach_rises: assert property (!length_clear_in && length_met |=> length_reached_out) // [R3]
    else $error("length reached output missing");

  a_len_below_low: assert property (!length_met |=> !length_reached_out) // [R2]
    else $error("length reached while below target");

  a_len_count_step: assert property (length_step && !length_clear_in // [R1]
    && length_count_monitor != 16'hFFFF
    |=> length_count_monitor == $past(length_count_monitor) + 16'h0001)
    else $error("length pulse not counted");

  a_count_saturates: assert property (event_count_monitor == 16'hFFFF // [R13]
    && !event_clear_in |=> event_count_monitor == 16'hFFFF)
    else $error("event count wrapped");

  a_evt_stops_final: assert property (final_reached_out && !event_clear_in // [R9]
    ##0 event_step |=> $stable(event_count_monitor))
    else $error("event count moved past final target");

  a_evt_inter_reach: assert property (!event_clear_in && event_enabled // [R8]
    && event_count_monitor >= intermediate_count_target_reg |=> intermediate_reached_out)
    else $error("intermediate reached output missing");

  a_evt_clear_all: assert property (event_clear_in |=> event_count_monitor == 16'h0000 // [R10]
    && !intermediate_reached_out && !final_reached_out)
    else $error("counter clear incomplete");

  a_evt_disabled_hold: assert property (!event_enabled && !event_clear_in |=> $stable(event_count_monitor)) // [R12]
    else $error("disabled event counter counted");

  a_evt_count_step: assert property (event_step && !event_hold && !event_clear_in // [R7]
    && event_count_monitor != 16'hFFFF
    |=> event_count_monitor == $past(event_count_monitor) + 16'h0001)
    else $error("event pulse not counted");

  a_mon_read_back: assert property (rd_done && avs_address_in == `PLEC_OFF_LENGTH_MONITOR // [R6]
    |-> avs_readdata_out[15:0] == $past(length_count_monitor))
    else $error("length monitor read wrong");

  a_final_sets_irq: assert property ($rose(final_reached_out) |-> irq_status_reg[2]) // [R9]
    else $error("final reach did not set status");

endmodule : plec_top

`default_nettype wire

//--- include/plec_cfg.svh
`ifndef PLEC_CFG_SVH
`define PLEC_CFG_SVH

// Register byte offsets on the Avalon-MM slave.
`define PLEC_OFF_TARGET_LENGTH 6'h00
`define PLEC_OFF_PULSES_PER_METRE 6'h04
`define PLEC_OFF_FINAL_TARGET 6'h08
`define PLEC_OFF_INTER_TARGET 6'h0C
`define PLEC_OFF_RESOLUTION 6'h10
`define PLEC_OFF_LENGTH_MONITOR 6'h14
`define PLEC_OFF_EVENT_MONITOR 6'h18
`define PLEC_OFF_IRQ_STATUS 6'h1C
`define PLEC_OFF_IRQ_MASK 6'h20
`define PLEC_OFF_FLAGS 6'h24
`define PLEC_OFF_FAST_SELECT 6'h28

// Reset values.
`define PLEC_RST_TARGET_LENGTH 16'h03E8
`define PLEC_RST_PULSES_PER_METRE 16'h03E8
`define PLEC_RST_FINAL_TARGET 16'h03E8
`define PLEC_RST_INTER_TARGET 16'h03E8
`define PLEC_RST_RESOLUTION 16'h0000
`define PLEC_RST_IRQ_MASK 3'h0
`define PLEC_RST_FAST_SELECT 16'h0000

// Fast input function codes.
`define PLEC_FSEL_EVENT 16'h0023
`define PLEC_FSEL_LENGTH 16'h0026

// Status, mask and flag bit positions.
`define PLEC_BIT_LENGTH 0
`define PLEC_BIT_INTER 1
`define PLEC_BIT_FINAL 2

// Counter limit and length scale factors (pulses per metre is held in tenths).
`define PLEC_COUNT_MAX 16'hFFFF
`define PLEC_SCALE_RES0 16'h000A
`define PLEC_SCALE_RES1 16'h0064
`define PLEC_SCALE_RES2 16'h03E8
`define PLEC_SCALE_RES3 16'h2710

`endif

//--- include/plec_pkg.sv
package plec_pkg;

  typedef logic [15:0] plec_word_t;

  typedef logic [2:0] plec_flags_t;

  typedef enum logic {
    PLEC_BUS_IDLE,
    PLEC_BUS_ANSWER
  } plec_bus_e;

endpackage : plec_pkg

//--- tb/plec_pulse_model.sv
`timescale 1ns/1ps
`default_nettype none

module plec_pulse_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Burst request
  input wire logic start_in,
  input wire logic [15:0] count_in,
  input wire logic [3:0] gap_in,
  // Sensor line
  output logic pulse_out,
  output logic busy_out
);
  logic [15:0] left_reg;
  logic [3:0] wait_reg;

  // Each pulse is one cycle high, followed by at least one low cycle, so every edge is seen.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      left_reg <= 16'h0000;
      wait_reg <= 4'h0;
      pulse_out <= 1'b0;
    end else if (start_in) begin
      left_reg <= count_in;
      wait_reg <= 4'h0;
      pulse_out <= 1'b0;
    end else if (pulse_out) begin
      pulse_out <= 1'b0;
      wait_reg <= gap_in;
    end else if (wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end else if (left_reg != 16'h0000) begin
      pulse_out <= 1'b1;
      left_reg <= left_reg - 16'h0001;
    end
  end

  assign busy_out = start_in | pulse_out | (left_reg != 16'h0000) | (wait_reg != 4'h0);
endmodule : plec_pulse_model

`default_nettype wire

//--- tb/pulse_length_and_event_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none

`include "plec_cfg.svh"

module pulse_length_and_event_counter_bench;
  localparam logic [5:0] LMON = `PLEC_OFF_LENGTH_MONITOR;
  localparam logic [5:0] EMON = `PLEC_OFF_EVENT_MONITOR;
  logic clk_in, rst_in, avs_read_in, avs_write_in, start, len_clr, evt_clr;
  logic [5:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [3:0] avs_byteenable_in, gap;
  logic avs_waitrequest_out, len_hit, mid_hit, fin_hit, irq, pulse, busy;
  logic [1:0] sel;
  logic [15:0] n_pulses;
  int miscompares, n_compared, cycles;

  plec_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .length_pulse_in(pulse & (sel == 2'h0)),
    .event_pulse_in(pulse & (sel == 2'h1)), .fast_pulse_input_in(pulse & (sel == 2'h2)),
    .length_clear_in(len_clr), .event_clear_in(evt_clr), .length_reached_out(len_hit),
    .intermediate_reached_out(mid_hit), .final_reached_out(fin_hit), .irq_out(irq));

  plec_pulse_model i_sensor (.clk_in(clk_in), .rst_in(rst_in), .start_in(start),
    .count_in(n_pulses), .gap_in(gap), .pulse_out(pulse), .busy_out(busy));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waitrequest and read data are looked at mid-cycle, where they stand settled for the coming edge.
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    logic waiting;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(negedge clk_in);
      waiting = (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      @(posedge clk_in);
    end while (waiting);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus

  task rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask : rchk

  task hits(input logic [2:0] exp);
    check({29'h0, fin_hit, mid_hit, len_hit}, {29'h0, exp});
  endtask : hits

  task send(input logic [1:0] s, input logic [15:0] n);
    @(posedge clk_in);
    sel <= s;
    n_pulses <= n;
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    do begin
      @(negedge clk_in);
    end while (busy !== 1'b0);
    repeat (2) @(posedge clk_in);
  endtask : send

  task clr(input logic l, input logic e);
    @(posedge clk_in);
    len_clr <= l;
    evt_clr <= e;
    @(posedge clk_in);
    len_clr <= 1'b0;
    evt_clr <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : clr

  task t_regs;
    rchk(`PLEC_OFF_TARGET_LENGTH, 32'h000003E8);
    rchk(`PLEC_OFF_PULSES_PER_METRE, 32'h000003E8);
    rchk(`PLEC_OFF_FINAL_TARGET, 32'h000003E8);
    rchk(`PLEC_OFF_INTER_TARGET, 32'h000003E8);
    rchk(`PLEC_OFF_RESOLUTION, 32'h00000000);
    rchk(`PLEC_OFF_IRQ_MASK, 32'h00000000);
    rchk(`PLEC_OFF_FAST_SELECT, 32'h00000000);
    bus(1'b1, `PLEC_OFF_RESOLUTION, 32'h00000003);
    rchk(`PLEC_OFF_RESOLUTION, 32'h00000003);
    bus(1'b1, `PLEC_OFF_RESOLUTION, 32'h00000000);
    bus(1'b1, EMON, 32'h00001234);
    rchk(EMON, 32'h00000000);
    bus(1'b1, 6'h2C, 32'h0000FFFF);
    rchk(6'h2C, 32'h00000000);
    $display("Test registers done");
  endtask : t_regs

  task t_event;
    gap <= 4'h1;
    bus(1'b1, `PLEC_OFF_FINAL_TARGET, 32'h00000008);
    bus(1'b1, `PLEC_OFF_INTER_TARGET, 32'h00000005);
    send(2'h1, 16'h0004);
    hits(3'h0);
    rchk(EMON, 32'h00000004);
    send(2'h1, 16'h0001);
    hits(3'h2);
    send(2'h1, 16'h0003);
    hits(3'h6);
    rchk(EMON, 32'h00000008);
    send(2'h1, 16'h0002);
    rchk(EMON, 32'h00000008);
    check({31'h0, irq}, 32'h00000000);
    bus(1'b1, `PLEC_OFF_IRQ_MASK, 32'h00000006);
    @(posedge clk_in);
    check({31'h0, irq}, 32'h00000001);
    rchk(`PLEC_OFF_IRQ_STATUS, 32'h00000006);
    @(posedge clk_in);
    check({31'h0, irq}, 32'h00000000);
    clr(1'b0, 1'b1);
    hits(3'h0);
    rchk(EMON, 32'h00000000);
    $display("Test event counter done");
  endtask : t_event

  task t_length;
    gap <= 4'h5;
    bus(1'b1, `PLEC_OFF_PULSES_PER_METRE, 32'h00000028);
    bus(1'b1, `PLEC_OFF_TARGET_LENGTH, 32'h00000002);
    send(2'h0, 16'h0007);
    hits(3'h0);
    rchk(LMON, 32'h00000007);
    send(2'h0, 16'h0001);
    hits(3'h1);
    rchk(`PLEC_OFF_IRQ_STATUS, 32'h00000001);
    clr(1'b1, 1'b0);
    hits(3'h0);
    rchk(LMON, 32'h00000000);
    $display("Test length counter done");
  endtask : t_length

  task t_fast;
    gap <= 4'h1;
    bus(1'b1, `PLEC_OFF_FAST_SELECT, {16'h0, `PLEC_FSEL_LENGTH});
    send(2'h2, 16'h0003);
    send(2'h0, 16'h0002);
    rchk(LMON, 32'h00000003);
    bus(1'b1, `PLEC_OFF_FAST_SELECT, {16'h0, `PLEC_FSEL_EVENT});
    send(2'h2, 16'h0003);
    send(2'h1, 16'h0001);
    rchk(EMON, 32'h00000003);
    bus(1'b1, `PLEC_OFF_FAST_SELECT, 32'h00000000);
    clr(1'b1, 1'b1);
    $display("Test fast input done");
  endtask : t_fast

  task t_off;
    bus(1'b1, `PLEC_OFF_FINAL_TARGET, 32'h00000000);
    bus(1'b1, `PLEC_OFF_INTER_TARGET, 32'h00000000);
    send(2'h1, 16'h0004);
    rchk(EMON, 32'h00000000);
    $display("Test disabled counter done");
  endtask : t_off

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    rst_in = 1'b1;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 6'h00;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'hF;
    start = 1'b0;
    len_clr = 1'b0;
    evt_clr = 1'b0;
    sel = 2'h3;
    n_pulses = 16'h0000;
    gap = 4'h1;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_event();
    t_length();
    t_fast();
    t_off();
    complete_run();
  end
endmodule : pulse_length_and_event_counter_bench

`default_nettype wire
